// *** src/system_clock_switch_control.sv ***
// Clock switch control: source select, oscillator enables, status and gating.
// Assumes fuse inputs are stable from reset; register port is synchronous to clk.
`timescale 1ns/1ps
module system_clock_switch_control
   import scsc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] clockConfigFuses,
   input wire logic [1:0] startupTimeFuses,
   input wire logic [1:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic sleepRequest,
   input wire logic sleepIdleMode,
   input wire logic extIntPin,
   output logic rcOscEnable,
   output logic extOscEnable,
   output logic rcClkGate,
   output logic extClkGate,
   output logic cpuClockSourceSel,
   output logic pllEnable,
   output logic usbClockFreeze,
   output logic cpuClkRun,
   output logic ioClkRun,
   output logic flashClkRun,
   output logic asyncWakeEvent
);

   scsc_osc_if rcOsc ();
   scsc_osc_if extOsc ();

   logic loadDone_reg;
   logic cpuSel_reg;
   logic [1:0] rc_startup_time_reg;
   logic [1:0] extSut_reg;
   logic [1:0] rcSutFuse_reg;
   logic [3:0] rcCfg_reg;
   logic [3:0] extCfg_reg;
   logic pllLocked_reg;
   logic [11:0] lockCount_reg;
   scsc_state_t state_reg;
   logic [1:0] gapCount_reg;
   logic pinToggle_reg;
   logic [2:0] wakeSync_reg;
   logic sleeping_reg;
   logic fuseIsExt;
   logic wrSrc;
   logic wrCfg;
   logic wrPll;
   logic wakeEvent;

   assign fuseIsExt = (decodeClockConfig(clockConfigFuses) == CFG_KIND_EXT_CLOCK) ||
                      (decodeClockConfig(clockConfigFuses) == CFG_KIND_LP_CRYSTAL);
   assign wrSrc = regWrite && loadDone_reg && (regAddr == ADDR_SOURCE_SELECT);
   assign wrCfg = regWrite && loadDone_reg && (regAddr == ADDR_CONFIG_SELECT);
   assign wrPll = regWrite && loadDone_reg && (regAddr == ADDR_PLL_CONTROL);

   // Trackers latch their start-up length on the load edge, so they see the fuses then
   assign rcOsc.enable = rcOscEnable;
   assign rcOsc.startupSel = loadDone_reg ? rcSutFuse_reg : startupTimeFuses;
   assign rcOsc.fastStart = 1'b0;
   assign extOsc.enable = extOscEnable;
   assign extOsc.startupSel = loadDone_reg ? extSut_reg : startupTimeFuses;
   assign extOsc.fastStart = loadDone_reg ?
                             (decodeClockConfig(extCfg_reg) == CFG_KIND_EXT_CLOCK) :
                             (decodeClockConfig(clockConfigFuses) == CFG_KIND_EXT_CLOCK);

   scsc_osc_tracker u_rcTracker (.clk(clk), .resetn(resetn), .osc(rcOsc.tracker));
   scsc_osc_tracker u_extTracker (.clk(clk), .resetn(resetn), .osc(extOsc.tracker));

   ////////////////////////////////////////////////////////////////////////////
   // Fuse load on the first edge after reset, then software writes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         loadDone_reg <= 1'b0;
         cpuSel_reg <= 1'b0;
         rcOscEnable <= 1'b0;
         extOscEnable <= 1'b0;
         rc_startup_time_reg <= 2'h0;
         extSut_reg <= 2'h0;
         rcSutFuse_reg <= 2'h0;
         rcCfg_reg <= RC_CONFIG_RESET;
         extCfg_reg <= EXT_CONFIG_RESET;
      end else if (!loadDone_reg) begin
         loadDone_reg <= 1'b1;
         cpuSel_reg <= fuseIsExt;
         extOscEnable <= fuseIsExt;
         rcOscEnable <= !fuseIsExt;
         if (fuseIsExt) begin
            extSut_reg <= startupTimeFuses;
            extCfg_reg <= clockConfigFuses;
         end else begin
            rc_startup_time_reg <= startupTimeFuses;
            rcSutFuse_reg <= startupTimeFuses;
         end
      end else begin
         if (wrSrc) begin
            cpuSel_reg <= regWdata[SRC_CPU_SEL_BIT];
            extOscEnable <= regWdata[SRC_EXT_EN_BIT];
            rcOscEnable <= regWdata[SRC_RC_EN_BIT];
            extSut_reg <= regWdata[SRC_EXT_SUT_LSB +: 2];
            rc_startup_time_reg <= regWdata[SRC_RC_SUT_LSB +: 2];
         end
         if (wrCfg) begin
            rcCfg_reg <= regWdata[CFG_RC_LSB +: 4];
            extCfg_reg <= regWdata[CFG_EXT_LSB +: 4];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port; unmapped bits and reserved status bits read zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         if (regAddr == ADDR_SOURCE_SELECT) begin
            regRdata <= {rc_startup_time_reg, extSut_reg, rcOscEnable, extOscEnable, 1'b0, cpuSel_reg};
         end else if (regAddr == ADDR_CONFIG_SELECT) begin
            regRdata <= {rcCfg_reg, extCfg_reg};
         end else if (regAddr == ADDR_RUN_STATUS) begin
            regRdata <= {6'h00, rcOsc.running, extOsc.running};
         end else begin
            regRdata <= {5'h00, usbClockFreeze, pllLocked_reg, pllEnable};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PLL enable, lock timer and USB clock freeze
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pllEnable <= 1'b0;
         usbClockFreeze <= 1'b1;
      end else if (wrPll) begin
         pllEnable <= regWdata[PLL_EN_BIT];
         usbClockFreeze <= regWdata[USB_FREEZE_BIT];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lockCount_reg <= 12'h000;
         pllLocked_reg <= 1'b0;
      end else if (!pllEnable) begin
         lockCount_reg <= 12'h000;
         pllLocked_reg <= 1'b0;
      end else if (!pllLocked_reg) begin
         lockCount_reg <= lockCount_reg + 12'h001;
         pllLocked_reg <= (lockCount_reg == 12'(PLL_LOCK_CYCLES - 1));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Break-before-make source change; the break starts only while the target is running, which is not checked again before it is gated in
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_RC;
         gapCount_reg <= 2'h0;
         rcClkGate <= 1'b1;
         extClkGate <= 1'b0;
         cpuClockSourceSel <= 1'b0;
      end else begin
         case (state_reg)
            ST_RC: begin
               if (cpuSel_reg && extOsc.running) begin
                  state_reg <= ST_BREAK_TO_EXT;
                  rcClkGate <= 1'b0;
                  gapCount_reg <= 2'h0;
               end
            end
            ST_BREAK_TO_EXT: begin
               gapCount_reg <= gapCount_reg + 2'h1;
               if (gapCount_reg == SWITCH_GAP_CYCLES - 2'h1) begin
                  state_reg <= ST_EXT;
                  extClkGate <= 1'b1;
                  cpuClockSourceSel <= 1'b1;
               end
            end
            ST_EXT: begin
               if (!cpuSel_reg && rcOsc.running) begin
                  state_reg <= ST_BREAK_TO_RC;
                  extClkGate <= 1'b0;
                  gapCount_reg <= 2'h0;
               end
            end
            ST_BREAK_TO_RC: begin
               gapCount_reg <= gapCount_reg + 2'h1;
               if (gapCount_reg == SWITCH_GAP_CYCLES - 2'h1) begin
                  state_reg <= ST_RC;
                  rcClkGate <= 1'b1;
                  cpuClockSourceSel <= 1'b0;
               end
            end
            default: begin
               state_reg <= ST_RC;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin-clocked toggle catches an edge with no system clock activity
   always_ff @(posedge extIntPin or negedge resetn) begin
      if (!resetn) begin
         pinToggle_reg <= 1'b0;
      end else begin
         pinToggle_reg <= !pinToggle_reg;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wakeSync_reg <= 3'h0;
         asyncWakeEvent <= 1'b0;
      end else begin
         wakeSync_reg <= {wakeSync_reg[1:0], pinToggle_reg};
         asyncWakeEvent <= wakeEvent;
      end
   end

   assign wakeEvent = wakeSync_reg[2] ^ wakeSync_reg[1];

   // Sleep gating; a wake in the same cycle as a sleep request wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sleeping_reg <= 1'b0;
         cpuClkRun <= 1'b1;
         flashClkRun <= 1'b1;
         ioClkRun <= 1'b1;
      end else begin
         if (wakeEvent) begin
            sleeping_reg <= 1'b0;
            cpuClkRun <= 1'b1;
            flashClkRun <= 1'b1;
            ioClkRun <= 1'b1;
         end else if (sleepRequest && !sleeping_reg) begin
            sleeping_reg <= 1'b1;
            cpuClkRun <= 1'b0;
            flashClkRun <= 1'b0;
            ioClkRun <= sleepIdleMode;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_gatesClosed;
      (!rcClkGate && !extClkGate)[*2];
   endsequence

   sequence s_breakToExt;
      s_gatesClosed ##1 (extClkGate && cpuClockSourceSel);
   endsequence

   property p_routeExt;
      @(posedge clk) disable iff (!resetn)
         cpuClockSourceSel |-> (extClkGate && !rcClkGate) || (state_reg == ST_BREAK_TO_RC);
   endproperty
   a_routeExt: assert property (p_routeExt) else $error("ext route mismatch");

   property p_fuseSelect;
      @(posedge clk) disable iff (!resetn)
         (loadDone_reg && !$past(loadDone_reg)) |-> (cpuSel_reg == fuseIsExt) && rcCfg_reg == 4'h2;
   endproperty
   a_fuseSelect: assert property (p_fuseSelect) else $error("fuse load wrong");

   property p_rcEnable;
      @(posedge clk) disable iff (!resetn)
         wrSrc |=> rcOscEnable == $past(regWdata[3]) ##1 (rcOscEnable || !rcOsc.running);
   endproperty
   a_rcEnable: assert property (p_rcEnable) else $error("rc enable wrong");

   property p_extEnable;
      @(posedge clk) disable iff (!resetn)
         wrSrc |=> extOscEnable == $past(regWdata[2]);
   endproperty
   a_extEnable: assert property (p_extEnable) else $error("ext enable wrong");

   property p_rcSutFixed;
      @(posedge clk) disable iff (!resetn)
         loadDone_reg |=> $stable(rcSutFuse_reg);
   endproperty
   a_rcSutFixed: assert property (p_rcSutFixed) else $error("rc delay changed");

   property p_statusReserved;
      @(posedge clk) disable iff (!resetn)
         (regRead && regAddr == ADDR_RUN_STATUS) |=> regRdata[7:2] == 6'h00;
   endproperty
   a_statusReserved: assert property (p_statusReserved) else $error("reserved set");

   property p_rcStops;
      @(posedge clk) disable iff (!resetn)
         !rcOscEnable |=> !rcOsc.running;
   endproperty
   a_rcStops: assert property (p_rcStops) else $error("rc still running");

   property p_extStops;
      @(posedge clk) disable iff (!resetn)
         !extOscEnable |=> !extOsc.running;
   endproperty
   a_extStops: assert property (p_extStops) else $error("ext still running");

   property p_glitchFree;
      @(posedge clk) disable iff (!resetn)
         $fell(rcClkGate) |-> s_breakToExt;
   endproperty
   a_glitchFree: assert property (p_glitchFree) else $error("gates overlap");

endmodule : system_clock_switch_control

// *** src/scsc_pkg.sv ***
// Constants, types and helpers shared by the clock switch control block.
// Assumes a single 40 MHz system clock and an 8-bit register port.
package scsc_pkg;

   localparam int CLK_PERIOD_NS = 25;

   // Register indexes on the two-bit register address
   localparam logic [1:0] ADDR_SOURCE_SELECT = 2'h0;
   localparam logic [1:0] ADDR_CONFIG_SELECT = 2'h1;
   localparam logic [1:0] ADDR_RUN_STATUS = 2'h2;
   localparam logic [1:0] ADDR_PLL_CONTROL = 2'h3;

   // clock_source_select fields
   localparam int SRC_CPU_SEL_BIT = 0;
   localparam int SRC_EXT_EN_BIT = 2;
   localparam int SRC_RC_EN_BIT = 3;
   localparam int SRC_EXT_SUT_LSB = 4;
   localparam int SRC_RC_SUT_LSB = 6;

   // clock_config_select fields
   localparam int CFG_EXT_LSB = 0;
   localparam int CFG_RC_LSB = 4;
   localparam logic [3:0] RC_CONFIG_RESET = 4'h2;
   localparam logic [3:0] EXT_CONFIG_RESET = 4'h0;

   // oscillator_running_status fields
   localparam int STA_EXT_RUN_BIT = 0;
   localparam int STA_RC_RUN_BIT = 1;

   // pll_control fields
   localparam int PLL_EN_BIT = 0;
   localparam int PLL_LOCK_BIT = 1;
   localparam int USB_FREEZE_BIT = 2;

   // PLL multiplies an 8 MHz input up to 48 MHz
   localparam int PLL_MULTIPLIER = 6;
   localparam int PLL_LOCK_NS = 100000;
   localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Oscillator start-up cycles per start-up code
   localparam logic [7:0] SUT_CYCLES_0 = 8'h04;
   localparam logic [7:0] SUT_CYCLES_1 = 8'h10;
   localparam logic [7:0] SUT_CYCLES_2 = 8'h40;
   localparam logic [7:0] SUT_CYCLES_3 = 8'hFF;
   localparam logic [7:0] EXT_CLOCK_START_CYCLES = 8'h06;

   // Cycles with both clock gates closed during a source change
   localparam logic [1:0] SWITCH_GAP_CYCLES = 2'h2;

   typedef enum logic [1:0] {
      CFG_KIND_RC,
      CFG_KIND_EXT_CLOCK,
      CFG_KIND_LP_CRYSTAL,
      CFG_KIND_RESERVED
   } scsc_cfg_kind_t;

   typedef enum logic [3:0] {
      ST_RC = 4'b0001,
      ST_BREAK_TO_EXT = 4'b0010,
      ST_EXT = 4'b0100,
      ST_BREAK_TO_RC = 4'b1000
   } scsc_state_t;

   function automatic scsc_cfg_kind_t decodeClockConfig(input logic [3:0] code);
      if (code[3]) begin
         return CFG_KIND_LP_CRYSTAL;
      end else if (code == 4'h2) begin
         return CFG_KIND_RC;
      end else if (code == 4'h0) begin
         return CFG_KIND_EXT_CLOCK;
      end
      return CFG_KIND_RESERVED;
   endfunction : decodeClockConfig

   function automatic logic [7:0] startupCycles(input logic [1:0] startup_time_fuses, input logic fastStart);
      if (fastStart) begin
         return EXT_CLOCK_START_CYCLES;
      end
      case (startup_time_fuses)
         2'h0: return SUT_CYCLES_0;
         2'h1: return SUT_CYCLES_1;
         2'h2: return SUT_CYCLES_2;
         default: return SUT_CYCLES_3;
      endcase
   endfunction : startupCycles

endpackage : scsc_pkg

// *** src/scsc_osc_if.sv ***
// Link between the control logic and one oscillator start-up tracker.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface scsc_osc_if;
   logic enable;
   logic [1:0] startupSel;
   logic fastStart;
   logic running;
   modport ctrl (output enable, output startupSel, output fastStart, input running);
   modport tracker (input enable, input startupSel, input fastStart, output running);
endinterface : scsc_osc_if

// *** src/scsc_osc_tracker.sv ***
// Start-up tracker for one oscillator: reports running after its start-up time.
// Assumes enable comes from a flip-flop in the clk domain.
`timescale 1ns/1ps
module scsc_osc_tracker
   import scsc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   scsc_osc_if.tracker osc
);

   logic [7:0] limit_reg;
   logic [7:0] count_reg;
   logic running_reg;

   assign osc.running = running_reg;

   // Start-up length is taken while stopped, so it applies at the next start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         limit_reg <= SUT_CYCLES_3;
      end else if (!osc.enable) begin
         limit_reg <= startupCycles(osc.startupSel, osc.fastStart);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= 8'h00;
         running_reg <= 1'b0;
      end else if (!osc.enable) begin
         count_reg <= 8'h00;
         running_reg <= 1'b0;
      end else if (!running_reg) begin
         count_reg <= count_reg + 8'h01;
         running_reg <= (count_reg == limit_reg - 8'h01);
      end
   end

endmodule : scsc_osc_tracker

// *** tb/tb.sv ***
// Self-checking bench for the clock switch control block.
// Assumes the register port, fuse inputs and sleep controls are driven here directly.
`timescale 1ns/1ps
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin badCount++; \
   $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
   import scsc_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] clockConfigFuses = 4'h2;
   logic [1:0] startupTimeFuses = 2'h1;
   logic [1:0] regAddr = 2'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regWdata = 8'h00;
   logic [7:0] regRdata;
   logic sleepRequest = 1'b0;
   logic sleepIdleMode = 1'b0;
   logic extIntPin = 1'b0;
   logic rcOscEnable, extOscEnable, rcClkGate, extClkGate, cpuClockSourceSel;
   logic pllEnable, usbClockFreeze, cpuClkRun, ioClkRun, flashClkRun, asyncWakeEvent;
   int badCount = 0;
   int nCompared = 0;
   int n;
   logic [7:0] d;
   logic [3:0] cfgTab [4] = '{4'h2, 4'h0, 4'hE, 4'h1};
   logic [1:0] sutTab [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
   logic [7:0] srcTab [4] = '{8'h48, 8'h35, 8'h25, 8'h08};
   logic [7:0] cfgRdTab [4] = '{8'h20, 8'h20, 8'h2E, 8'h20};

   system_clock_switch_control system_clock_switch_control_i (
      .clk(clk), .resetn(resetn), .clockConfigFuses(clockConfigFuses),
      .startupTimeFuses(startupTimeFuses), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .sleepRequest(sleepRequest), .sleepIdleMode(sleepIdleMode), .extIntPin(extIntPin),
      .rcOscEnable(rcOscEnable), .extOscEnable(extOscEnable), .rcClkGate(rcClkGate),
      .extClkGate(extClkGate), .cpuClockSourceSel(cpuClockSourceSel),
      .pllEnable(pllEnable), .usbClockFreeze(usbClockFreeze), .cpuClkRun(cpuClkRun),
      .ioClkRun(ioClkRun), .flashClkRun(flashClkRun), .asyncWakeEvent(asyncWakeEvent)
   );

   initial begin
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic reportAndStop();
      $display("compared %0d, mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : reportAndStop

   task automatic doReset(input logic [3:0] cfg, input logic [1:0] startup_time_fuses);
      resetn <= 1'b0;
      clockConfigFuses <= cfg;
      startupTimeFuses <= startup_time_fuses;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      // Load edge, then first request edge
      @(posedge clk);
      #1;
   endtask : doReset

   task automatic regWr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask : regWr

   task automatic regRd(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      v = regRdata;
   endtask : regRd

   task automatic regChk(input logic [1:0] a, input logic [7:0] exp);
      logic [7:0] v;
      regRd(a, v);
      `CHK(v, exp)
   endtask : regChk

   // Polls a register until the masked value matches; counts the reads used
   task automatic waitReg(input logic [1:0] a, input logic [7:0] m, input logic [7:0] val,
                          input int maxReads, output int reads);
      logic [7:0] v;
      reads = 0;
      do begin
         regRd(a, v);
         reads++;
         if (reads > maxReads) begin
            badCount++;
            $display("unexpected at %0t: got %h expected %h", $time, v & m, val);
            reportAndStop();
         end
      end while ((v & m) !== val);
   endtask : waitReg

   // Waits for the active source to change, checking the gates never overlap
   task automatic waitSel(input logic v, input int maxCycles);
      int i;
      for (i = 0; i < maxCycles; i++) begin
         @(posedge clk);
         #1;
         `CHK(rcClkGate & extClkGate, 1'b0)
         if (cpuClockSourceSel === v) begin
            break;
         end
      end
      `CHK(cpuClockSourceSel, v)
      `CHK(extClkGate, v)
      `CHK(rcClkGate, ~v)
      if (cpuClockSourceSel !== v) begin
         reportAndStop();
      end
   endtask : waitSel

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      doReset(4'h2, 2'h1);
      `CHK(usbClockFreeze, 1'b1)
      `CHK(pllEnable, 1'b0)
      `CHK({cpuClkRun, ioClkRun, flashClkRun}, 3'h7)
      regChk(ADDR_SOURCE_SELECT, 8'h48);
      regChk(ADDR_CONFIG_SELECT, 8'h20);
      regChk(ADDR_PLL_CONTROL, 8'h04);
      waitReg(ADDR_RUN_STATUS, 8'h02, 8'h02, 20, n);
      regChk(ADDR_RUN_STATUS, 8'h02);
      // Selecting a source that is not running must not switch
      regWr(ADDR_SOURCE_SELECT, 8'h49);
      repeat (10) @(posedge clk);
      `CHK(cpuClockSourceSel, 1'b0)
      regWr(ADDR_SOURCE_SELECT, 8'h4D);
      `CHK(extOscEnable, 1'b1)
      waitReg(ADDR_RUN_STATUS, 8'h01, 8'h01, 10, n);
      waitSel(1'b1, 20);
      // RC off, then on again with the fuse start-up code; the written code only reads back
      regWr(ADDR_SOURCE_SELECT, 8'hC5);
      `CHK(rcOscEnable, 1'b0)
      waitReg(ADDR_RUN_STATUS, 8'h02, 8'h00, 5, n);
      regChk(ADDR_SOURCE_SELECT, 8'hC5);
      regWr(ADDR_SOURCE_SELECT, 8'hCD);
      `CHK(rcOscEnable, 1'b1)
      waitReg(ADDR_RUN_STATUS, 8'h02, 8'h02, 20, n);
      // Suspend sequence to RC
      regWr(ADDR_PLL_CONTROL, 8'h04);
      regWr(ADDR_SOURCE_SELECT, 8'hCC);
      waitSel(1'b0, 20);
      regWr(ADDR_SOURCE_SELECT, 8'hC8);
      `CHK(extOscEnable, 1'b0)
      waitReg(ADDR_RUN_STATUS, 8'h01, 8'h00, 5, n);
      // Crystal start with the longest rewritten start-up code
      regWr(ADDR_CONFIG_SELECT, 8'h28);
      regChk(ADDR_CONFIG_SELECT, 8'h28);
      regWr(ADDR_SOURCE_SELECT, 8'hF8);
      regWr(ADDR_SOURCE_SELECT, 8'hFC);
      waitReg(ADDR_RUN_STATUS, 8'h01, 8'h01, 200, n);
      `CHK(n > 60, 1'b1)
      // Wake sequence back to the external source
      regWr(ADDR_SOURCE_SELECT, 8'hFD);
      waitSel(1'b1, 20);
      regWr(ADDR_PLL_CONTROL, 8'h05);
      `CHK(pllEnable, 1'b1)
      regWr(ADDR_SOURCE_SELECT, 8'hF5);
      waitReg(ADDR_PLL_CONTROL, 8'h02, 8'h02, 2500, n);
      `CHK(n > 1900, 1'b1)
      regChk(ADDR_PLL_CONTROL, 8'h07);
      regWr(ADDR_PLL_CONTROL, 8'h01);
      `CHK(usbClockFreeze, 1'b0)
      regChk(ADDR_PLL_CONTROL, 8'h03);
      regWr(ADDR_PLL_CONTROL, 8'h02);
      regChk(ADDR_PLL_CONTROL, 8'h00);
      // Status is hardware driven only
      regWr(ADDR_RUN_STATUS, 8'hFF);
      regChk(ADDR_RUN_STATUS, 8'h01);
      // Sleep in both modes, woken by the interrupt pin
      for (int m = 1; m >= 0; m--) begin
         @(posedge clk);
         sleepIdleMode <= m[0];
         sleepRequest <= 1'b1;
         @(posedge clk);
         sleepRequest <= 1'b0;
         #1;
         `CHK({cpuClkRun, ioClkRun, flashClkRun}, {1'b0, m[0], 1'b0})
         @(posedge clk);
         extIntPin <= 1'b1;
         for (n = 0; n < 8 && asyncWakeEvent !== 1'b1; n++) begin
            @(posedge clk);
            #1;
         end
         `CHK(asyncWakeEvent, 1'b1)
         if (asyncWakeEvent !== 1'b1) begin
            reportAndStop();
         end
         @(posedge clk);
         extIntPin <= 1'b0;
         #1;
         `CHK(asyncWakeEvent, 1'b0)
         `CHK({cpuClkRun, ioClkRun, flashClkRun}, 3'h7)
      end
      // Fuse-driven reset values for each kind of configuration code
      for (int k = 0; k < 4; k++) begin
         doReset(cfgTab[k], sutTab[k]);
         regChk(ADDR_SOURCE_SELECT, srcTab[k]);
         regChk(ADDR_CONFIG_SELECT, cfgRdTab[k]);
         // Fuse start-up code 2 on a crystal holds the switch off for 64 cycles
         if (k == 2) begin
            repeat (40) @(posedge clk);
            #1;
            `CHK(cpuClockSourceSel, 1'b0)
         end
         waitSel(srcTab[k][0], 300);
      end
      reportAndStop();
   end
endmodule : tb
